// ===== eda_regs.vh
/*
  Register map, field positions, reset values and timing counts of the
  data nonvolatile access controller. Assumes a 250 MHz core clock.
*/
`ifndef EDA_REGS_VH
`define EDA_REGS_VH

// Byte offsets on the AXI4-Lite bus
`define EDA_OFS_ADDR    8'h00
`define EDA_OFS_DATA    8'h04
`define EDA_OFS_CTRL    8'h08
`define EDA_OFS_KEY     8'h0C
`define EDA_OFS_STAT    8'h10
`define EDA_OFS_MASK    8'h14

// Control register fields
`define EDA_CTRL_RD     0
`define EDA_CTRL_WR     1
`define EDA_CTRL_ARM    2
`define EDA_CTRL_PSEL   7

// Status and mask field
`define EDA_STAT_DONE   0

// Unlock key values
`define EDA_KEY_FIRST   8'h55
`define EDA_KEY_SECOND  8'hAA

// Reset values
`define EDA_RST_ADDR    8'h00
`define EDA_RST_DATA    8'h00
`define EDA_RST_MASK    1'h0

// Array geometry
`define EDA_ADDR_W      8
`define EDA_MEM_DEPTH   256

// Timing: clock rate and array write time
`define EDA_CLK_MHZ     250
`define EDA_WRITE_TIME_NS 2000
`define EDA_WRITE_CYCLES ((`EDA_WRITE_TIME_NS * `EDA_CLK_MHZ + 999) / 1000)

// AXI responses
`define EDA_RESP_OKAY   2'h0
`define EDA_RESP_SLVERR 2'h2

`endif

// ===== eda_array.v
/*
  Byte-wide data array with one write port and one registered read port.
  Assumes the caller never reads and writes in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eda_regs.vh"

module eda_array (
  input  wire                   clk,
  input  wire                   ce,
  input  wire                   we,
  input  wire [`EDA_ADDR_W-1:0] waddr,
  input  wire [7:0]             wdata,
  input  wire                   re,
  input  wire [`EDA_ADDR_W-1:0] raddr,
  output reg  [7:0]             rdata
);

  reg [7:0] mem [0:`EDA_MEM_DEPTH-1];

  // Array contents survive reset, as a nonvolatile store should
  always @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read data, held until the next read
  always @(posedge clk) begin
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

// ===== eda_top.v
/*
  Data nonvolatile access controller: address, data, control and unlock
  key registers on an AXI4-Lite slave, armed and unlocked array writes,
  register-triggered reads, busy status and a completion interrupt.
  Assumes one clock, synchronous active-high reset, and a master that keeps
  at most one write and one read outstanding.
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "eda_regs.vh"

module eda_top #(
  parameter WRITE_CYCLES = `EDA_WRITE_CYCLES
) (
  input  wire        CLK,
  input  wire        RST,
  input  wire        CE,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output wire        IRQ
);

  localparam ST_IDLE = 3'b001;
  localparam ST_KEY1 = 3'b010;
  localparam ST_KEY2 = 3'b100;
  // Counter is 16 bits wide; the end point is cut to that width on purpose
  localparam integer WR_LAST_I = WRITE_CYCLES - 1;
  localparam [15:0]  WR_LAST   = WR_LAST_I[15:0];

  // Bus capture
  reg [7:0]  aw_addr;
  reg        aw_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        w_held;

  // Block state
  reg [`EDA_ADDR_W-1:0] nvm_address_reg;
  reg [7:0]             data_latch;
  reg                   show_array;
  reg                   program_arm;
  reg                   program_space_select;
  reg                   busy;
  reg [15:0]            wr_count;
  reg [`EDA_ADDR_W-1:0] wr_addr;
  reg [7:0]             wr_byte;
  reg [2:0]             key_state;
  reg                   program_done_flag;
  reg                   done_mask;
  reg                   rd_pending;
  wire [7:0]            array_q;

  // Address decode shared by both bus directions
  function mapped;
    input [7:0] a;
    begin
      case (a)
        `EDA_OFS_ADDR, `EDA_OFS_DATA, `EDA_OFS_CTRL,
        `EDA_OFS_KEY, `EDA_OFS_STAT, `EDA_OFS_MASK: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // Channels accept independently; nothing moves while CE is low
  assign S_AXI_AWREADY = CE & ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = CE & ~w_held & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = CE & ~S_AXI_RVALID;

  wire       do_wr  = CE & aw_held & w_held & ~S_AXI_BVALID;
  wire       byte_w = do_wr & w_strb[0];
  wire [7:0] wb     = w_data[7:0];
  wire       do_rd  = S_AXI_ARVALID & S_AXI_ARREADY;
  // Low address bits ignored on reads as on writes
  wire [7:0] ar_word = {S_AXI_ARADDR[7:2], 2'b00};

  wire wr_addr_reg = byte_w && aw_addr == `EDA_OFS_ADDR;
  wire wr_data_reg = byte_w && aw_addr == `EDA_OFS_DATA;
  wire wr_ctrl     = byte_w && aw_addr == `EDA_OFS_CTRL;
  wire wr_key      = byte_w && aw_addr == `EDA_OFS_KEY;
  wire wr_mask     = byte_w && aw_addr == `EDA_OFS_MASK;
  wire rd_stat     = do_rd && ar_word == `EDA_OFS_STAT;

  // Read start: data space chosen by the value being written
  wire start_rd = wr_ctrl & wb[`EDA_CTRL_RD] & ~wb[`EDA_CTRL_PSEL] & ~busy;
  // Arm must already be stored; the incoming arm bit does not count
  wire start_wr = wr_ctrl & wb[`EDA_CTRL_WR] & ~wb[`EDA_CTRL_PSEL]
                & program_arm
                & (key_state == ST_KEY2)
                & ~busy;
  wire wr_done  = CE & busy & (wr_count == WR_LAST);

  wire [7:0] data_view = show_array ? array_q : data_latch;

  // Write address and data capture
  always @(posedge CLK) begin
    if (RST) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[7:2], 2'b00};
      end else if (do_wr) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (do_wr) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer with an error
  always @(posedge CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `EDA_RESP_OKAY;
    end else if (CE) begin
      if (do_wr) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= mapped(aw_addr) ? `EDA_RESP_OKAY : `EDA_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Read data; trigger bit reflects a running write
  always @(posedge CLK) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP  <= `EDA_RESP_OKAY;
      S_AXI_RDATA  <= 32'h00000000;
    end else if (CE) begin
      if (do_rd) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= mapped(ar_word) ? `EDA_RESP_OKAY : `EDA_RESP_SLVERR;
        case (ar_word)
          `EDA_OFS_ADDR: S_AXI_RDATA <= {24'h000000, nvm_address_reg};
          `EDA_OFS_DATA: S_AXI_RDATA <= {24'h000000, data_view};
          `EDA_OFS_CTRL: S_AXI_RDATA <= {24'h000000, program_space_select, 4'h0,
                                         program_arm, busy, rd_pending};
          `EDA_OFS_STAT: S_AXI_RDATA <= {31'h00000000, program_done_flag};
          `EDA_OFS_MASK: S_AXI_RDATA <= {31'h00000000, done_mask};
          default:       S_AXI_RDATA <= 32'h00000000;
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Unlock sequencer: any other register write drops the unlock
  always @(posedge CLK) begin
    if (RST) begin
      key_state <= ST_IDLE;
    end else if (CE && do_wr) begin
      case (key_state)
        ST_IDLE: key_state <= (wr_key && wb == `EDA_KEY_FIRST) ? ST_KEY1 : ST_IDLE;
        ST_KEY1: begin
          if (wr_key && wb == `EDA_KEY_SECOND) begin
            key_state <= ST_KEY2;
          end else if (wr_key && wb == `EDA_KEY_FIRST) begin
            key_state <= ST_KEY1;
          end else begin
            key_state <= ST_IDLE;
          end
        end
        // Unlock is spent by the very next write, triggered or not
        ST_KEY2: key_state <= (wr_key && wb == `EDA_KEY_FIRST) ? ST_KEY1 : ST_IDLE;
        default: key_state <= ST_IDLE;
      endcase
    end
  end

  // Address, data and control registers
  always @(posedge CLK) begin
    if (RST) begin
      nvm_address_reg      <= `EDA_RST_ADDR;
      data_latch           <= `EDA_RST_DATA;
      show_array           <= 1'b0;
      program_arm          <= 1'b0;
      program_space_select <= 1'b0;
      rd_pending           <= 1'b0;
      done_mask            <= `EDA_RST_MASK;
    end else if (CE) begin
      rd_pending <= start_rd;
      if (wr_addr_reg) begin
        nvm_address_reg <= wb[`EDA_ADDR_W-1:0];
      end
      // Array output shown until firmware overwrites it
      if (start_rd) begin
        show_array <= 1'b1;
      end else if (wr_data_reg) begin
        show_array <= 1'b0;
        data_latch <= wb;
      end
      // Arm may drop at any time; a running write ignores it
      if (wr_ctrl) begin
        program_arm          <= wb[`EDA_CTRL_ARM];
        program_space_select <= wb[`EDA_CTRL_PSEL];
      end
      if (wr_mask) begin
        done_mask <= wb[`EDA_STAT_DONE];
      end
    end
  end

  // Write cycle timer, address and byte captured at start
  always @(posedge CLK) begin
    if (RST) begin
      busy     <= 1'b0;
      wr_count <= 16'h0000;
      wr_addr  <= `EDA_RST_ADDR;
      wr_byte  <= `EDA_RST_DATA;
    end else if (CE) begin
      if (start_wr) begin
        busy     <= 1'b1;
        wr_count <= 16'h0000;
        wr_addr  <= nvm_address_reg;
        wr_byte  <= data_view;
      end else if (wr_done) begin
        busy <= 1'b0;
      end else if (busy) begin
        wr_count <= wr_count + 16'h0001;
      end
    end
  end

  // Done flag: a completion in the clearing read's cycle still sets it
  always @(posedge CLK) begin
    if (RST) begin
      program_done_flag <= 1'b0;
    end else if (CE) begin
      if (wr_done) begin
        program_done_flag <= 1'b1;
      end else if (rd_stat) begin
        program_done_flag <= 1'b0;
      end
    end
  end

  assign IRQ = program_done_flag & done_mask;

  // Array commits the byte at the end of the timed cycle
  eda_array u_array (
    .clk   (CLK),
    .ce    (CE),
    .we    (wr_done),
    .waddr (wr_addr),
    .wdata (wr_byte),
    .re    (start_rd),
    .raddr (nvm_address_reg),
    .rdata (array_q)
  );

endmodule
`default_nettype wire

// ===== eda_chk.sv
/*
  Bus timing checker for eda_top, bound to its ports.
  Assumes CE stays high around the handshakes it times.
*/
`timescale 1ns/1ps
`default_nettype none
module eda_chk #(parameter WRITE_CYCLES = 500) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        IRQ
);
  // One domain, reset masks every check
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_b_latency: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && CE |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  a_r_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY && CE |=> S_AXI_RVALID)
    else $error("read response late");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answering");
  a_aw_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answering");
  a_byte_only: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_reset_idle: assert property ($past(RST) |-> !S_AXI_BVALID && !S_AXI_RVALID && !IRQ)
    else $error("outputs busy after reset");
endmodule
bind eda_top eda_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.CLK(CLK), .RST(RST), .CE(CE),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .IRQ(IRQ));
`default_nettype wire

// ===== eeprom_data_access_control_tb_top.sv
/*
  Self-checking bench for eda_top over AXI4-Lite.
  Assumes eda_regs.vh on the include path; short write time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eda_regs.vh"
module eeprom_data_access_control_tb_top;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        ce = 1'h1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  wire logic   awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  logic [31:0] v;
  logic [1:0]  resp;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          wd;

  // Write time cut short so busy polling stays cheap
  eda_top #(.WRITE_CYCLES(32)) DUT (.CLK(clk), .RST(rst), .CE(ce), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ(irq));

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One edge under a watchdog, so a dead handshake ends the run
  task automatic tick();
    @(posedge clk);
    wd++;
    if (wd > 200) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // Address and data offered together, each dropped when taken; handshakes are
  // judged at the falling edge, where what the next rising edge samples is settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_on;
    logic w_on;
    logic b_on;
    logic aw_go;
    logic w_go;
    logic b_go;
    aw_on = 1'h1;
    w_on = 1'h1;
    b_on = 1'h1;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (aw_on || w_on || b_on) begin
      @(negedge clk);
      aw_go = aw_on && awready;
      w_go = w_on && wready;
      b_go = b_on && bvalid;
      if (b_go) resp = bresp;
      tick();
      if (aw_go) begin
        aw_on = 1'h0;
        awvalid <= 1'h0;
      end
      if (w_go) begin
        w_on = 1'h0;
        wvalid <= 1'h0;
      end
      if (b_go) begin
        b_on = 1'h0;
        bready <= 1'h0;
      end
    end
    // One idle edge, so the next call never drives a line twice in a time step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar_on;
    logic r_on;
    logic ar_go;
    logic r_go;
    ar_on = 1'h1;
    r_on = 1'h1;
    wd = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (ar_on || r_on) begin
      @(negedge clk);
      ar_go = ar_on && arready;
      r_go = r_on && rvalid;
      if (r_go) begin
        v = rdata;
        resp = rresp;
      end
      tick();
      if (ar_go) begin
        ar_on = 1'h0;
        arvalid <= 1'h0;
      end
      if (r_go) begin
        r_on = 1'h0;
        rready <= 1'h0;
      end
    end
    @(posedge clk);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, v, e);
  endtask

  // Two key writes back to back
  task automatic unlock();
    wr(`EDA_OFS_KEY, {24'h0, `EDA_KEY_FIRST});
    wr(`EDA_OFS_KEY, {24'h0, `EDA_KEY_SECOND});
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rc("ctrl", `EDA_OFS_CTRL, 32'h0);
    rc("stat", `EDA_OFS_STAT, 32'h0);
    rc("mask", `EDA_OFS_MASK, 32'h0);
    rc("key", `EDA_OFS_KEY, 32'h0);
    rc("hole", 8'h18, 32'h0);
    chk("hole resp", {30'h0, resp}, {30'h0, `EDA_RESP_SLVERR});
    rc("ctrl resp", `EDA_OFS_CTRL, 32'h0);
    chk("ctrl rresp", {30'h0, resp}, {30'h0, `EDA_RESP_OKAY});
    wr(8'h18, 32'h0);
    chk("hole wresp", {30'h0, resp}, {30'h0, `EDA_RESP_SLVERR});
    $display("reset test done");
    // Clock enable low freezes the block and closes every ready
    ce <= 1'h0;
    @(posedge clk);
    @(negedge clk);
    chk("frozen ready", {29'h0, awready, wready, arready}, 32'h0);
    @(posedge clk);
    ce <= 1'h1;
    $display("enable test done");
    wr(`EDA_OFS_ADDR, 32'h3C);
    chk("wresp", {30'h0, resp}, {30'h0, `EDA_RESP_OKAY});
    wr(`EDA_OFS_DATA, 32'hA5);
    wr(`EDA_OFS_CTRL, 32'h04);
    unlock();
    wr(`EDA_OFS_CTRL, 32'h06);
    rc("busy", `EDA_OFS_CTRL, 32'h06);
    wr(`EDA_OFS_CTRL, 32'h00);
    rc("busy disarmed", `EDA_OFS_CTRL, 32'h02);
    for (int i = 0; i < 40 && v[1] !== 1'h0; i++) rd(`EDA_OFS_CTRL);
    chk("busy end", v, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`EDA_OFS_MASK, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    rc("done", `EDA_OFS_STAT, 32'h1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rc("done clear", `EDA_OFS_STAT, 32'h0);
    $display("write test done");
    wr(`EDA_OFS_DATA, 32'h0);
    wr(`EDA_OFS_CTRL, 32'h01);
    rc("read", `EDA_OFS_DATA, 32'hA5);
    rc("read hold", `EDA_OFS_DATA, 32'hA5);
    wr(`EDA_OFS_DATA, 32'h5A);
    rc("data write", `EDA_OFS_DATA, 32'h5A);
    $display("read test done");
    unlock();
    wr(`EDA_OFS_CTRL, 32'h06);
    rc("arm with trigger", `EDA_OFS_CTRL, 32'h04);
    wr(`EDA_OFS_CTRL, 32'h06);
    rc("no keys", `EDA_OFS_CTRL, 32'h04);
    wr(`EDA_OFS_KEY, {24'h0, `EDA_KEY_FIRST});
    wr(`EDA_OFS_ADDR, 32'h3C);
    wr(`EDA_OFS_KEY, {24'h0, `EDA_KEY_SECOND});
    wr(`EDA_OFS_CTRL, 32'h06);
    rc("split keys", `EDA_OFS_CTRL, 32'h04);
    wr(`EDA_OFS_CTRL, 32'h84);
    unlock();
    wr(`EDA_OFS_CTRL, 32'h86);
    rc("space select", `EDA_OFS_CTRL, 32'h84);
    wr(`EDA_OFS_CTRL, 32'h01);
    rc("array kept", `EDA_OFS_DATA, 32'hA5);
    rc("no done", `EDA_OFS_STAT, 32'h0);
    $display("refusal test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
